/* rtl/pfil_pkg.sv */
// fault interrupt logic: shared constants, flag layout and state codes
// assumes a single 125 MHz core clock and an active-low async reset
package pfil_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_REG = 4;   // regulators with under/overvoltage sense
  localparam int NUM_MON = 2;   // external voltage monitors
  localparam int NUM_GRP = 4;   // rail groups
  localparam int GRP_W = 2;     // group select width
  localparam int TRIG_W = 2;    // rail trigger code width per group
  localparam int DEST_W = 2;    // startup destination width
  localparam int NUM_HITS = 4;  // one per trigger code

  // ==========================================================================
  // flag vector layout (live sources first, same index in live vector)
  localparam int F_REG_UV = 0;
  localparam int F_REG_OV = 4;
  localparam int F_SUP_OV = 8;
  localparam int F_SUP_UV = 9;
  localparam int F_MON_OV = 10;
  localparam int F_MON_UV = 12;
  localparam int F_MON_RV = 14;
  localparam int F_TWARN = 16;
  localparam int F_TSD_ORD = 17;
  localparam int F_TSD_IMM = 18;
  localparam int F_BIST = 19;
  localparam int F_CRC = 20;
  localparam int NUM_LIVE = 19;
  localparam int NUM_FLAG = 21;

  // flags a mask can gate
  localparam logic [NUM_FLAG-1:0] FLAG_MASKABLE = 21'h193fff;
  // flags that report a live status bit
  localparam logic [NUM_FLAG-1:0] FLAG_HAS_LIVE = 21'h073fff;
  // flags whose clear is refused while the condition persists
  localparam logic [NUM_FLAG-1:0] FLAG_HOLD = 21'h013fff;

  // ==========================================================================
  // rail trigger codes per group
  localparam logic [TRIG_W-1:0] TRIG_NONE = 2'h0;
  localparam logic [TRIG_W-1:0] TRIG_ALARM = 2'h1;
  localparam logic [TRIG_W-1:0] TRIG_ORDERLY = 2'h2;
  localparam logic [TRIG_W-1:0] TRIG_IMMED = 2'h3;

  // ==========================================================================
  // reset values
  localparam logic [DEST_W-1:0] DEST_RST = 2'h0;

  // shutdown sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_THERM_ORD = 2'b01,
    ST_THERM_IMM = 2'b10,
    ST_FAULT = 2'b11
  } pfil_state_t;

endpackage

/* rtl/pfil_flag.sv */
// fault interrupt logic: bank of sticky write-one-to-clear flags
// assumes set, hold and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pfil_flag #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] hold_in,
  input wire logic [W-1:0] clear_in,
  output logic [W-1:0] flag_out
);

  typedef struct packed {
    logic [W-1:0] flag;
  } pfil_flag_s_t;

  pfil_flag_s_t s;
  pfil_flag_s_t next_s;

  // ==========================================================================
  // set beats clear; clear refused while hold is high
  always_comb begin
    next_s = s;
    next_s.flag = set_in | (s.flag & ~(clear_in & ~hold_in));
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag_out = s.flag;

endmodule // pfil_flag
`default_nettype wire

/* rtl/pfil_top.sv */
// fault interrupt logic: flags, triggers and thermal/fault shutdown sequencer
// assumes analog comparator levels are asynchronous; clears, masks, config
// and the self-test and crc pulses come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module pfil_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [pfil_pkg::NUM_REG-1:0] reg_undervolt_in,
  input wire logic [pfil_pkg::NUM_REG-1:0] reg_overvolt_in,
  input wire logic supply_overvolt_in,
  input wire logic supply_undervolt_in,
  input wire logic [pfil_pkg::NUM_MON-1:0] monitor_overvolt_in,
  input wire logic [pfil_pkg::NUM_MON-1:0] monitor_undervolt_in,
  input wire logic [pfil_pkg::NUM_MON-1:0] monitor_residual_in,
  input wire logic thermal_warning_in,
  input wire logic thermal_orderly_in,
  input wire logic thermal_immediate_in,
  input wire logic self_test_fail_in,
  input wire logic reg_crc_error_in,
  input wire logic [pfil_pkg::NUM_FLAG-1:0] flag_clear_in,
  input wire logic [pfil_pkg::NUM_FLAG-1:0] flag_mask_in,
  input wire logic [pfil_pkg::NUM_REG*pfil_pkg::GRP_W-1:0]
    regulator_group_select_in,
  input wire logic [pfil_pkg::GRP_W-1:0] supply_group_select_in,
  input wire logic [pfil_pkg::NUM_MON*pfil_pkg::GRP_W-1:0]
    monitor_group_select_in,
  input wire logic [pfil_pkg::NUM_GRP*pfil_pkg::TRIG_W-1:0]
    group_rail_trigger_in,
  input wire logic [pfil_pkg::NUM_MON-1:0] monitor_residual_check_select_in,
  input wire logic [pfil_pkg::DEST_W-1:0] startup_destination_state_in,
  output logic [pfil_pkg::NUM_REG-1:0] reg_undervolt_flag_out,
  output logic [pfil_pkg::NUM_REG-1:0] reg_overvolt_flag_out,
  output logic supply_overvolt_flag_out,
  output logic supply_undervolt_flag_out,
  output logic [pfil_pkg::NUM_MON-1:0] monitor_overvolt_flag_out,
  output logic [pfil_pkg::NUM_MON-1:0] monitor_undervolt_flag_out,
  output logic [pfil_pkg::NUM_MON-1:0] monitor_residual_flag_out,
  output logic thermal_warning_flag_out,
  output logic thermal_orderly_shutdown_flag_out,
  output logic thermal_immediate_shutdown_flag_out,
  output logic self_test_failure_flag_out,
  output logic reg_crc_error_flag_out,
  output logic [pfil_pkg::NUM_FLAG-1:0] live_status_out,
  output logic int_req_out,
  output logic mcu_alarm_out,
  output logic moderate_error_flag_out,
  output logic severe_error_flag_out,
  output logic regs_disable_out,
  output logic pulldown_en_out,
  output logic gpio_low_seq_out,
  output logic gpio_low_now_out,
  output logic restart_out,
  output logic [pfil_pkg::DEST_W-1:0] restart_dest_out
);
  import pfil_pkg::*;

  typedef struct packed {
    logic [NUM_LIVE-1:0] sync1;
    logic [NUM_LIVE-1:0] sync2;
    logic [NUM_LIVE-1:0] prev;
    logic [NUM_FLAG-1:0] live;
    pfil_state_t st;
    logic int_req;
    logic alarm;
    logic moderate;
    logic severe;
    logic dis;
    logic pd;
    logic gseq;
    logic gnow;
    logic restart;
    logic [DEST_W-1:0] dest;
  } pfil_top_s_t;

  pfil_top_s_t s;
  pfil_top_s_t next_s;
  logic [NUM_LIVE-1:0] raw;
  logic [NUM_LIVE-1:0] live_g;
  logic [NUM_LIVE-1:0] rise;
  logic [NUM_HITS-1:0] hits;
  logic [NUM_FLAG-1:0] flag_q;
  logic [NUM_FLAG-1:0] set_v;
  logic [NUM_FLAG-1:0] hold_v;
  logic [NUM_FLAG-1:0] eff_mask;
  logic cooled;

  // trigger code of the group a source belongs to
  function automatic logic [TRIG_W-1:0] trig_code(
    input logic [GRP_W-1:0] g);
    trig_code = group_rail_trigger_in[g*TRIG_W +: TRIG_W];
  endfunction

  // ==========================================================================
  // flag bank
  // asynchronous comparator levels in flag order
  assign raw = {thermal_immediate_in, thermal_orderly_in, thermal_warning_in,
    monitor_residual_in, monitor_undervolt_in, monitor_overvolt_in,
    supply_undervolt_in, supply_overvolt_in, reg_overvolt_in,
    reg_undervolt_in};

  // live sources set; crc and self-test pulses set directly
  assign set_v = {reg_crc_error_in, self_test_fail_in, live_g};
  // clear refused while fault persists
  assign hold_v = {2'h0, s.sync2} & FLAG_HOLD;
  // residual and shutdown flags cannot be masked
  assign eff_mask = flag_mask_in & FLAG_MASKABLE;
  assign cooled = ~|s.sync2[F_TWARN +: 3];

  pfil_flag #(
    .W(NUM_FLAG)
  ) u_flags (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(set_v),
    .hold_in(hold_v),
    .clear_in(flag_clear_in),
    .flag_out(flag_q)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    // two-flop synchroniser, then edge history
    next_s.sync1 = raw;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    // residual check disabled means no flag and no trigger
    live_g = s.sync2;
    live_g[F_MON_RV +: NUM_MON] = s.sync2[F_MON_RV +: NUM_MON] &
      monitor_residual_check_select_in;
    rise = live_g & ~s.prev;
    // grouped rail triggers
    hits = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      if (rise[F_REG_UV+i] || rise[F_REG_OV+i]) begin
        hits[trig_code(regulator_group_select_in[i*GRP_W +: GRP_W])] = 1'b1;
      end
    end
    if (rise[F_SUP_OV] || rise[F_SUP_UV]) begin
      hits[trig_code(supply_group_select_in)] = 1'b1;
    end
    for (int i = 0; i < NUM_MON; i++) begin
      if (rise[F_MON_OV+i] || rise[F_MON_UV+i] ||
          rise[F_MON_RV+i]) begin
        hits[trig_code(monitor_group_select_in[i*GRP_W +: GRP_W])] = 1'b1;
      end
    end
    // fixed moderate and severe sources
    if (rise[F_TSD_ORD] || self_test_fail_in || reg_crc_error_in) begin
      hits[TRIG_ORDERLY] = 1'b1;
    end
    if (rise[F_TSD_IMM]) begin
      hits[TRIG_IMMED] = 1'b1;
    end
    // thermal warning raises nothing besides its flag
    next_s.alarm = hits[TRIG_ALARM];
    next_s.moderate = hits[TRIG_ORDERLY];
    next_s.severe = hits[TRIG_IMMED];
    next_s.live = {2'h0, s.sync2} & FLAG_HAS_LIVE;
    next_s.int_req = |(flag_q & ~eff_mask);
    next_s.restart = 1'b0;
    // shutdown sequencer
    unique case (s.st)
      ST_RUN: begin
        if (rise[F_TSD_IMM]) begin
          next_s.st = ST_THERM_IMM;
        end else if (rise[F_TSD_ORD]) begin
          next_s.st = ST_THERM_ORD;
        end else if (self_test_fail_in || reg_crc_error_in) begin
          next_s.st = ST_FAULT;
        end
      end
      ST_THERM_ORD, ST_THERM_IMM: begin
        if (rise[F_TSD_IMM]) begin
          next_s.st = ST_THERM_IMM;
        end else if (cooled) begin
          next_s.st = ST_RUN;
          next_s.restart = 1'b1;
          next_s.dest = startup_destination_state_in;
        end
      end
      ST_FAULT: begin
        if (rise[F_TSD_IMM]) begin
          next_s.st = ST_THERM_IMM;
        end else if (rise[F_TSD_ORD]) begin
          next_s.st = ST_THERM_ORD;
        end else begin
          next_s.st = ST_RUN;
          next_s.restart = 1'b1;
          next_s.dest = startup_destination_state_in;
        end
      end
    endcase
    // power outputs follow the new state
    next_s.dis = (next_s.st != ST_RUN);
    next_s.pd = (next_s.st == ST_THERM_IMM);
    next_s.gseq = (next_s.st == ST_THERM_ORD);
    next_s.gnow = (next_s.st == ST_THERM_IMM) || (next_s.st == ST_FAULT);
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
      s.st <= ST_RUN;
      s.dest <= DEST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_undervolt_flag_out = flag_q[F_REG_UV +: NUM_REG];
  assign reg_overvolt_flag_out = flag_q[F_REG_OV +: NUM_REG];
  assign supply_overvolt_flag_out = flag_q[F_SUP_OV];
  assign supply_undervolt_flag_out = flag_q[F_SUP_UV];
  assign monitor_overvolt_flag_out = flag_q[F_MON_OV +: NUM_MON];
  assign monitor_undervolt_flag_out = flag_q[F_MON_UV +: NUM_MON];
  assign monitor_residual_flag_out = flag_q[F_MON_RV +: NUM_MON];
  assign thermal_warning_flag_out = flag_q[F_TWARN];
  assign thermal_orderly_shutdown_flag_out = flag_q[F_TSD_ORD];
  assign thermal_immediate_shutdown_flag_out = flag_q[F_TSD_IMM];
  assign self_test_failure_flag_out = flag_q[F_BIST];
  assign reg_crc_error_flag_out = flag_q[F_CRC];
  assign live_status_out = s.live;
  assign int_req_out = s.int_req;
  assign mcu_alarm_out = s.alarm;
  assign moderate_error_flag_out = s.moderate;
  assign severe_error_flag_out = s.severe;
  assign regs_disable_out = s.dis;
  assign pulldown_en_out = s.pd;
  assign gpio_low_seq_out = s.gseq;
  assign gpio_low_now_out = s.gnow;
  assign restart_out = s.restart;
  assign restart_dest_out = s.dest;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_reg_uv_hold;
    s.sync2[F_REG_UV] && flag_clear_in[F_REG_UV] |=> flag_q[F_REG_UV];
  endproperty
  a_reg_uv_hold: assert property (p_reg_uv_hold)
    else $error("undervoltage flag cleared while fault present");
  property p_reg_uv_trig;
    rise[F_REG_UV] && trig_code(regulator_group_select_in[1:0]) ==
      TRIG_IMMED |=> severe_error_flag_out;
  endproperty
  a_reg_uv_trig: assert property (p_reg_uv_trig)
    else $error("undervoltage did not raise grouped trigger");
  property p_sup_ov_hold;
    s.sync2[F_SUP_OV] && flag_clear_in[F_SUP_OV] |=> flag_q[F_SUP_OV];
  endproperty
  a_sup_ov_hold: assert property (p_sup_ov_hold)
    else $error("supply overvoltage flag cleared while present");
  property p_sup_uv_hold;
    s.sync2[F_SUP_UV] |=> supply_undervolt_flag_out &&
      live_status_out[F_SUP_UV];
  endproperty
  a_sup_uv_hold: assert property (p_sup_uv_hold)
    else $error("supply undervoltage flag or live bit missing");
  property p_rv_off;
    !monitor_residual_check_select_in[0] && !flag_q[F_MON_RV] |=>
      !flag_q[F_MON_RV];
  endproperty
  a_rv_off: assert property (p_rv_off)
    else $error("residual flag set with check disabled");
  property p_rv_clear;
    flag_clear_in[F_MON_RV] && !live_g[F_MON_RV] |=> !flag_q[F_MON_RV];
  endproperty
  a_rv_clear: assert property (p_rv_clear)
    else $error("residual flag not cleared by write one");
  property p_twarn_only;
    rise == (NUM_LIVE'(1) << F_TWARN) && !self_test_fail_in &&
      !reg_crc_error_in |=> !moderate_error_flag_out &&
      !severe_error_flag_out && !mcu_alarm_out && thermal_warning_flag_out;
  endproperty
  a_twarn_only: assert property (p_twarn_only)
    else $error("thermal warning caused a transition");
  property p_tsd_ord;
    rise[F_TSD_ORD] && !rise[F_TSD_IMM] && s.st == ST_RUN |=>
      moderate_error_flag_out && gpio_low_seq_out && regs_disable_out;
  endproperty
  a_tsd_ord: assert property (p_tsd_ord)
    else $error("orderly shutdown not sequenced");
  property p_restart;
    (s.st == ST_THERM_ORD || s.st == ST_THERM_IMM) && cooled |=>
      restart_out && restart_dest_out == $past(startup_destination_state_in);
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart after cooling");
  property p_tsd_imm;
    rise[F_TSD_IMM] |=> severe_error_flag_out && pulldown_en_out &&
      gpio_low_now_out && regs_disable_out;
  endproperty
  a_tsd_imm: assert property (p_tsd_imm)
    else $error("immediate shutdown not applied");
  property p_bist;
    self_test_fail_in && s.st == ST_RUN && !rise[F_TSD_ORD] &&
      !rise[F_TSD_IMM] |=> gpio_low_now_out ##1 restart_out;
  endproperty
  a_bist: assert property (p_bist)
    else $error("self-test failure did not shut down and restart");
  property p_mask;
    (flag_q & ~eff_mask) == '0 |=> !int_req_out;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked flag raised interrupt request");

endmodule // pfil_top
`default_nettype wire

/* tb/pfil_host.sv */
// host model: services sticky fault flags with write-one-to-clear strobes
// assumes flags, restart and disable come from the fault logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module pfil_host (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic svc_in,
  input wire logic restart_in,
  input wire logic shutdown_in,
  input wire logic [pfil_pkg::NUM_FLAG-1:0] flag_in,
  output logic [pfil_pkg::NUM_FLAG-1:0] clear_out
);
  import pfil_pkg::*;
  logic recovered;
  // ==========================================================================
  // service pass: one-cycle clear of every set flag except shutdown flags before recovery, driven off the edge
  always @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clear_out <= 21'h0;
      recovered <= 1'b0;
    end else begin
      // shutdown flags are only touched once the device came back
      if (restart_in) recovered <= 1'b1;
      else if (shutdown_in) recovered <= 1'b0;
      clear_out <= svc_in ?
        (flag_in & {2'h3, {2{recovered}}, 17'h1ffff}) : 21'h0;
    end
  end
endmodule // pfil_host
`default_nettype wire

/* tb/tb_pfil_top.sv */
// testbench of the fault interrupt logic with a host servicing model
// assumes the package constants and the 3-edge level path of the design
`timescale 1ns/1ps
`default_nettype none
module tb_pfil_top;
  import pfil_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [18:0] lv = 19'h0;
  logic bist = 1'b0, crc = 1'b0, svc = 1'b0;
  logic [20:0] mask = 21'h0;
  logic [7:0] rgs = 8'h0, trig = 8'h0;
  logic [3:0] mgs = 4'h0;
  logic [1:0] sgs = 2'h0, rvs = 2'h0, dest = 2'h0;
  wire [20:0] fv, live, clr;
  wire irq, alarm, modr, sev, dis, pdn, gseq, gnow, rst_p;
  wire [1:0] rdest;
  int fail_count = 0;
  int n_compared = 0;

  // ==========================================================================
  // clock and units
  initial forever #4 clk = ~clk;

  pfil_top uut (.clk_in(clk), .nrst_in(nrst),
    .reg_undervolt_in(lv[3:0]), .reg_overvolt_in(lv[7:4]),
    .supply_overvolt_in(lv[8]), .supply_undervolt_in(lv[9]),
    .monitor_overvolt_in(lv[11:10]), .monitor_undervolt_in(lv[13:12]),
    .monitor_residual_in(lv[15:14]), .thermal_warning_in(lv[16]),
    .thermal_orderly_in(lv[17]), .thermal_immediate_in(lv[18]),
    .self_test_fail_in(bist), .reg_crc_error_in(crc),
    .flag_clear_in(clr), .flag_mask_in(mask),
    .regulator_group_select_in(rgs), .supply_group_select_in(sgs),
    .monitor_group_select_in(mgs), .group_rail_trigger_in(trig),
    .monitor_residual_check_select_in(rvs),
    .startup_destination_state_in(dest),
    .reg_undervolt_flag_out(fv[3:0]), .reg_overvolt_flag_out(fv[7:4]),
    .supply_overvolt_flag_out(fv[8]), .supply_undervolt_flag_out(fv[9]),
    .monitor_overvolt_flag_out(fv[11:10]),
    .monitor_undervolt_flag_out(fv[13:12]),
    .monitor_residual_flag_out(fv[15:14]),
    .thermal_warning_flag_out(fv[16]),
    .thermal_orderly_shutdown_flag_out(fv[17]),
    .thermal_immediate_shutdown_flag_out(fv[18]),
    .self_test_failure_flag_out(fv[19]), .reg_crc_error_flag_out(fv[20]),
    .live_status_out(live), .int_req_out(irq), .mcu_alarm_out(alarm),
    .moderate_error_flag_out(modr), .severe_error_flag_out(sev),
    .regs_disable_out(dis), .pulldown_en_out(pdn),
    .gpio_low_seq_out(gseq), .gpio_low_now_out(gnow),
    .restart_out(rst_p), .restart_dest_out(rdest));

  pfil_host host (.clk_in(clk), .nrst_in(nrst), .svc_in(svc),
    .restart_in(rst_p), .shutdown_in(dis), .flag_in(fv), .clear_out(clr));

  // ==========================================================================
  // compares, expectations and host service
  task automatic chk_vec(input logic [20:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string m);
    chk_vec({20'h0, got}, {20'h0, exp}, m);
  endtask

  // group of a level source in flag order
  function automatic logic [1:0] grp_of(input int i);
    if (i < 8) return rgs[2*(i%4)+:2];
    if (i < 10) return sgs;
    return mgs[2*((i-10)%2)+:2];
  endfunction

  // expected {severe, moderate, alarm} pulses for a trigger code
  function automatic logic [2:0] pulse_exp(input logic [1:0] c);
    return {c == TRIG_IMMED, c == TRIG_ORDERLY, c == TRIG_ALARM};
  endfunction

  task automatic host_clear;
    @(negedge clk) svc <= 1'b1;
    @(negedge clk) svc <= 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(56));
    repeat (6) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    @(posedge clk);
    // thermal shutdown, orderly then immediate, each with auto restart
    for (int k = 0; k < 2; k++) begin
      logic kb;
      @(negedge clk);
      kb = k[0];
      mask = 21'h1fffff;
      dest = 2'($urandom);
      lv[16] = 1'b1;
      lv[17+k] = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_bit(fv[17+k], 1'b1, "tsd flag");
      chk_bit(live[17+k], 1'b1, "tsd live");
      chk_vec({15'h0, sev, modr, dis, pdn, gseq, gnow},
        {15'h0, kb, ~kb, 1'b1, kb, ~kb, kb}, "tsd act");
      @(posedge clk) #1;
      chk_bit(irq, 1'b1, "tsd unmaskable");
      @(negedge clk) lv[16] = 1'b0;
      lv[17+k] = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_vec({17'h0, rst_p, dis, rdest}, {17'h0, 1'b1, 1'b0, dest},
        "restart");
      host_clear;
      chk_vec(fv, 21'h0, "tsd clear");
      $display("test thermal %0d done", k);
    end
    // self-test failure and register crc error
    for (int k = 0; k < 2; k++) begin
      logic m;
      @(negedge clk);
      m = 1'($urandom);
      mask = 21'(m) << (19 + k);
      dest = 2'($urandom);
      {crc, bist} = 2'h1 << k;
      @(negedge clk) {crc, bist} = 2'h0;
      #1;
      chk_vec({17'h0, fv[19+k], modr, gnow, dis}, 21'hf, "act");
      @(posedge clk) #1;
      chk_vec({18'h0, rst_p, rdest}, {18'h0, 1'b1, dest}, "rst");
      chk_bit(irq, ~m, "mask");
      host_clear;
      chk_vec(fv, 21'h0, "bist clear");
      $display("test fault %0d done", k);
    end
    // level sources with random masks, groups and trigger codes
    for (int i = 0; i < 17; i++) begin
      logic m, hold, hit;
      logic [2:0] pe;
      @(negedge clk);
      mask = 21'($urandom);
      m = mask[i];
      {rgs, trig, mgs, sgs, rvs} = 24'($urandom);
      if (i == 14) rvs = 2'h0;
      if (i == 15) rvs = 2'h2;
      if (i == 0) trig = 8'hff;
      hold = i < 14 || i == 16;
      hit = hold || rvs[i-14];
      pe = (hit && i != 16) ? pulse_exp(trig[2*grp_of(i)+:2]) : 3'h0;
      lv[i] = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_vec(fv, 21'(hit) << i, "set");
      chk_bit(live[i], hold, "live");
      chk_vec({18'h0, sev, modr, alarm}, {18'h0, pe},
        "trig");
      @(posedge clk) #1;
      chk_bit(irq, hit && !(m && hold), "irq");
      if (hold) begin
        host_clear;
        chk_vec(fv, 21'(1) << i, "held");
      end
      @(negedge clk) lv[i] = 1'b0;
      repeat (3) @(posedge clk);
      host_clear;
      chk_vec(fv, 21'h0, "clear");
    end
    $display("test levels done");
    end_sim();
  end
endmodule // tb_pfil_top
`default_nettype wire
